// ### hw/apl_defs.svh
// Behaviour
// - Sync-enabled write loads trigger current sync count
// - Trigger previous sync loads from write data
// - State sync register behaves identically
// - Fast correction increments amount, target correct
// - Stamps derive from target counts each event
// - Pending pulse count also raised by each target correction amount
// - Next active edge recomputes stamps from targets
`ifndef APL_DEFS_SVH
`define APL_DEFS_SVH
// =====================================================
// Register offsets
`define APL_OFS_CTRL 8'h00
`define APL_OFS_TSYNC 8'h04
`define APL_OFS_SSYNC 8'h08
`define APL_OFS_TAR 8'h0c
`define APL_OFS_TAR_OLD 8'h10
`define APL_OFS_TSTAMP 8'h14
`define APL_OFS_SSTAMP 8'h18
`define APL_OFS_ADDAMT 8'h1c
`define APL_OFS_ISR 8'h20
`define APL_OFS_IMR 8'h24
`define APL_OFS_PCNT 8'h28
`define APL_OFS_STAT 8'h2c
// =====================================================
// Field positions
`define APL_CTRL_WSE 0
`define APL_CTRL_REQ 1
`define APL_CTRL_INCSEL 2
`define APL_CTRL_TRIG 3
`define APL_CTRL_AMT_LSB 8
`define APL_SYNC_CUR_LSB 0
`define APL_SYNC_PREV_LSB 8
`define APL_ISR_DONE 0
`define APL_ISR_INACT 1
`define APL_ISR_ACT 2
// =====================================================
// Reset values
`define APL_CTRL_RST 16'h0000
`define APL_SYNC_RST 8'h00
`define APL_CNT_RST 16'h0000
`define APL_IRQ_RST 3'h0
`endif

// ### hw/apl_pkg.sv
package apl_pkg;
  // =====================================================
  // Types
  typedef enum logic [1:0] {
    APL_IDLE = 2'h0,
    APL_RUN = 2'h1,
    APL_DONE = 2'h2
  } apl_fsm_e;
  typedef logic [15:0] apl_cnt_t;
  typedef logic [7:0] apl_sync_t;
endpackage : apl_pkg

// ### hw/apl_sync.sv
`timescale 1ns/1ps
// =====================================================
// Two-stage synchroniser for a pin level
module apl_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic syncOut
);
  logic stage1_r;
  // First stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1_r <= pinIn;
      syncOut <= stage1_r;
    end
  end
endmodule : apl_sync

// ### hw/apl_angle_pll.sv
`timescale 1ns/1ps
`include "apl_defs.svh"
// =====================================================
// Angle tracking PLL sync count and pulse correction
module apl_angle_pll (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic inputEdgePin,
  input wire logic switchOnFlag,
  output logic irq,
  output logic microTick
);
  logic edgeSync;
  logic edgeDly_r;
  logic [15:0] ctrl_r;
  apl_pkg::apl_sync_t trigCur_r, trigPrev_r, stateCur_r, statePrev_r;
  apl_pkg::apl_cnt_t tar_r, tarOld_r, trigStamp_r, stateStamp_r, addAmt_r;
  apl_pkg::apl_cnt_t pending_r, pulseCnt_r;
  logic [2:0] isr_r, imr_r;
  apl_pkg::apl_fsm_e fsm_r, fsm_nxt;

  // =====================================================
  // Input edge synchronisation
  apl_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(inputEdgePin),
    .syncOut(edgeSync)
  );
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) edgeDly_r <= 1'b0;
    else edgeDly_r <= edgeSync;
  end
  wire activeEdge = edgeSync & ~edgeDly_r;
  wire inactiveEdge = ~edgeSync & edgeDly_r;

  // =====================================================
  // Address decode
  wire wrCtrl = regWr && (regAddr == `APL_OFS_CTRL);
  wire wrTsync = regWr && (regAddr == `APL_OFS_TSYNC);
  wire wrSsync = regWr && (regAddr == `APL_OFS_SSYNC);
  wire wrTar = regWr && (regAddr == `APL_OFS_TAR);
  wire wrTarOld = regWr && (regAddr == `APL_OFS_TAR_OLD);
  wire wrIsr = regWr && (regAddr == `APL_OFS_ISR);
  wire wrImr = regWr && (regAddr == `APL_OFS_IMR);
  wire syncEn = ctrl_r[`APL_CTRL_WSE];
  wire [7:0] corrAmt = ctrl_r[`APL_CTRL_AMT_LSB +: 8];
  wire apl_pkg::apl_cnt_t corrAmt16 = {8'h00, corrAmt};
  wire apl_pkg::apl_sync_t wCur = regWdata[`APL_SYNC_CUR_LSB +: 8];
  wire apl_pkg::apl_sync_t wPrev = regWdata[`APL_SYNC_PREV_LSB +: 8];
  wire corrStart = wrCtrl && regWdata[`APL_CTRL_TRIG] && regWdata[`APL_CTRL_REQ]
                   && (fsm_r == apl_pkg::APL_IDLE);
  wire corrRun = (fsm_r == apl_pkg::APL_RUN);
  wire corrDone = (fsm_r == apl_pkg::APL_DONE);
  wire apl_pkg::apl_cnt_t tarSel = switchOnFlag ? tar_r : tarOld_r;

  // =====================================================
  // Correction sequencer
  always_comb begin
    case (fsm_r)
      apl_pkg::APL_IDLE: fsm_nxt = corrStart ? apl_pkg::APL_RUN : apl_pkg::APL_IDLE;
      apl_pkg::APL_RUN: fsm_nxt = apl_pkg::APL_DONE;
      apl_pkg::APL_DONE: fsm_nxt = apl_pkg::APL_IDLE;
      default: fsm_nxt = apl_pkg::APL_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) fsm_r <= apl_pkg::APL_IDLE;
    else fsm_r <= fsm_nxt;
  end

  // Control register, trigger bit cleared by hardware when done
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ctrl_r <= `APL_CTRL_RST;
    else if (wrCtrl) begin
      ctrl_r <= regWdata[15:0];
      ctrl_r[`APL_CTRL_TRIG] <= corrStart | (ctrl_r[`APL_CTRL_TRIG] & ~corrDone);
    end else if (corrDone) ctrl_r[`APL_CTRL_TRIG] <= 1'b0;
  end

  // =====================================================
  // Sync count registers, both fields from write data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trigCur_r <= `APL_SYNC_RST;
      trigPrev_r <= `APL_SYNC_RST;
    end else if (wrTsync && syncEn) begin
      trigCur_r <= wCur;
      trigPrev_r <= wPrev;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateCur_r <= `APL_SYNC_RST;
      statePrev_r <= `APL_SYNC_RST;
    end else if (wrSsync && syncEn) begin
      stateCur_r <= wCur;
      statePrev_r <= wPrev;
    end
  end

  // =====================================================
  // Target counts; correction adds to the selected one, write wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tar_r <= `APL_CNT_RST;
      tarOld_r <= `APL_CNT_RST;
      addAmt_r <= `APL_CNT_RST;
    end else begin
      if (wrTar) tar_r <= regWdata[15:0];
      else if (corrRun && switchOnFlag) tar_r <= tar_r + corrAmt16;
      if (wrTarOld) tarOld_r <= regWdata[15:0];
      else if (corrRun && !switchOnFlag) tarOld_r <= tarOld_r + corrAmt16;
      if (corrRun) addAmt_r <= addAmt_r + corrAmt16;
    end
  end

  // Position stamps advance by the target at each active edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trigStamp_r <= `APL_CNT_RST;
      stateStamp_r <= `APL_CNT_RST;
    end else if (activeEdge) begin
      trigStamp_r <= trigStamp_r + tarSel;
      stateStamp_r <= stateStamp_r + tarSel;
    end
  end

  // =====================================================
  // Microtick generation, pending count reloaded from the selected target at each active edge
  wire tickNow = (pending_r != 16'h0000);
  wire apl_pkg::apl_cnt_t pendDec = tickNow ? pending_r - 16'h0001 : pending_r;
  wire apl_pkg::apl_cnt_t pendBase = activeEdge ? tarSel : pendDec;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending_r <= `APL_CNT_RST;
      pulseCnt_r <= `APL_CNT_RST;
      microTick <= 1'b0;
    end else begin
      pending_r <= corrRun ? pendBase + corrAmt16 : pendBase;
      pulseCnt_r <= pulseCnt_r + {15'h0000, tickNow};
      microTick <= tickNow;
    end
  end

  // =====================================================
  // Interrupts: set wins over write-one clear
  wire [2:0] isrSet = {activeEdge, inactiveEdge, corrDone};
  wire [2:0] isrClr = wrIsr ? regWdata[2:0] : 3'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      isr_r <= `APL_IRQ_RST;
      imr_r <= `APL_IRQ_RST;
      irq <= 1'b0;
    end else begin
      isr_r <= (isr_r & ~isrClr) | isrSet;
      if (wrImr) imr_r <= regWdata[2:0];
      irq <= |(((isr_r & ~isrClr) | isrSet) & (wrImr ? regWdata[2:0] : imr_r));
    end
  end

  // =====================================================
  // Read mux, unmapped reads return zero
  logic [31:0] rdMux;
  always_comb begin
    case (regAddr)
      `APL_OFS_CTRL: rdMux = {16'h0000, ctrl_r};
      `APL_OFS_TSYNC: rdMux = {16'h0000, trigPrev_r, trigCur_r};
      `APL_OFS_SSYNC: rdMux = {16'h0000, statePrev_r, stateCur_r};
      `APL_OFS_TAR: rdMux = {16'h0000, tar_r};
      `APL_OFS_TAR_OLD: rdMux = {16'h0000, tarOld_r};
      `APL_OFS_TSTAMP: rdMux = {16'h0000, trigStamp_r};
      `APL_OFS_SSTAMP: rdMux = {16'h0000, stateStamp_r};
      `APL_OFS_ADDAMT: rdMux = {16'h0000, addAmt_r};
      `APL_OFS_ISR: rdMux = {29'h0, isr_r};
      `APL_OFS_IMR: rdMux = {29'h0, imr_r};
      `APL_OFS_PCNT: rdMux = {16'h0000, pulseCnt_r};
      `APL_OFS_STAT: rdMux = {30'h0, corrRun | corrDone, switchOnFlag};
      default: rdMux = 32'h00000000;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) regRdata <= 32'h00000000;
    else if (regRd) regRdata <= rdMux;
  end

  // =====================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_start; corrStart; endsequence
  // Trigger is set, held through RUN and DONE, and reads low three edges on
  sequence s_finish; ##3 !ctrl_r[`APL_CTRL_TRIG]; endsequence
  a_trig_sync_load: assert property (wrTsync && syncEn |=> trigCur_r == $past(wCur))
    else $error("trigger current sync not loaded");
  a_trig_prev_load: assert property (wrTsync && syncEn |=> trigPrev_r == $past(wPrev))
    else $error("trigger previous sync not from write data");
  a_state_sync_load: assert property (wrSsync && syncEn |=> statePrev_r == $past(wPrev)
    && stateCur_r == $past(wCur))
    else $error("state sync fields not loaded");
  a_sync_hold: assert property (!(wrTsync && syncEn) |=> $stable(trigCur_r)
    && $stable(trigPrev_r))
    else $error("trigger sync changed without enabled write");
  a_amt_incr: assert property (corrRun |=> addAmt_r == $past(addAmt_r) + $past(corrAmt16))
    else $error("additional pulse amount not incremented");
  a_trig_clear: assert property (s_start |-> s_finish)
    else $error("correction trigger not cleared");
  a_stamp_update: assert property (activeEdge |=> trigStamp_r == $past(trigStamp_r)
    + $past(tarSel))
    else $error("trigger stamp not recomputed");
  a_tick_follows: assert property (tickNow |=> microTick && pulseCnt_r == $past(pulseCnt_r)
    + 16'h0001)
    else $error("microtick lost");
  a_irq_level: assert property (|(isr_r & imr_r) |-> irq || $past(wrIsr || wrImr))
    else $error("irq low with unmasked status");
endmodule : apl_angle_pll

// ### verif/test_apl_angle_pll.sv
`timescale 1ns/1ps
`include "apl_defs.svh"
// =====================================================
// Register level bench for the sync count and pulse fix
module test_apl_angle_pll;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic inputEdgePin = 1'b0;
  logic switchOnFlag = 1'b0;
  logic irq;
  logic microTick;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] v;
  logic [31:0] t0;
  logic [31:0] s0;
  logic [7:0] syncOfs [2] = '{`APL_OFS_TSYNC, `APL_OFS_SSYNC};
  logic [31:0] tarVal;
  int ticks;

  apl_angle_pll i_dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inputEdgePin(inputEdgePin),
    .switchOnFlag(switchOnFlag), .irq(irq), .microTick(microTick));

  // Clock at 25 MHz
  always #20 sys_clk = ~sys_clk;

  // =====================================================
  // Bus tasks and compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // Start a correction and poll, bounded, for the trigger to clear
  task automatic run_corr(input logic [31:0] c);
    logic [31:0] r;
    bit done;
    done = 1'b0;
    wr(`APL_OFS_CTRL, c);
    for (int i = 0; i < 50 && !done; i++) begin
      rd(`APL_OFS_CTRL, r);
      if (r[`APL_CTRL_TRIG] === 1'b0) done = 1'b1;
    end
    if (!done) begin
      errors++;
      test_done();
    end
  endtask : run_corr

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic test_done;
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // =====================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`APL_OFS_CTRL, v); chk("ctrl reset", 32'h0, v);
    rd(`APL_OFS_TSYNC, v); chk("tsync reset", 32'h0, v);
    chk("irq reset", 32'h0, {31'h0, irq});
    // Sync writes ignored while write-sync is off
    foreach (syncOfs[i]) begin
      wr(syncOfs[i], 32'h3412);
      rd(syncOfs[i], v); chk("sync locked", 32'h0, v);
    end
    wr(`APL_OFS_CTRL, 32'h1);
    // Both fields come straight from write data
    foreach (syncOfs[i]) begin
      wr(syncOfs[i], 32'h3412);
      rd(syncOfs[i], v); chk("sync first", 32'h3412, v);
      wr(syncOfs[i], 32'h5678);
      rd(syncOfs[i], v); chk("sync second", 32'h5678, v);
      wr(syncOfs[i], {16'h0, v[7:0], 8'h9a});
      rd(syncOfs[i], v); chk("sync inherit", 32'h789a, v);
    end
    rd(8'hfc, v); chk("unmapped", 32'h0, v);
    // Fast correction with increment select low
    wr(`APL_OFS_IMR, 32'h1);
    run_corr(32'h020b);
    rd(`APL_OFS_ADDAMT, v); chk("added amount", 32'h2, v);
    rd(`APL_OFS_TAR_OLD, v); chk("old target", 32'h2, v);
    rd(`APL_OFS_TAR, v); chk("current target kept", 32'h0, v);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq done", 32'h1, {31'h0, irq});
    rd(`APL_OFS_ISR, v); chk("isr done", 32'h1, v & 32'h1);
    wr(`APL_OFS_ISR, 32'h1);
    wr(`APL_OFS_IMR, 32'h0);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    // Active edges with rewritten targets, current then old
    for (int k = 0; k < 2; k++) begin
      switchOnFlag <= (k == 0);
      tarVal = (k == 0) ? 32'h4 : 32'h3;
      wr((k == 0) ? `APL_OFS_TAR : `APL_OFS_TAR_OLD, tarVal);
      rd(`APL_OFS_TSTAMP, t0);
      rd(`APL_OFS_SSTAMP, s0);
      inputEdgePin <= 1'b1;
      ticks = 0;
      repeat (30) begin
        @(posedge sys_clk);
        #1 if (microTick === 1'b1) ticks++;
      end
      chk("tick count", tarVal, ticks);
      rd(`APL_OFS_TSTAMP, v); chk("trig stamp", t0 + tarVal, v);
      rd(`APL_OFS_SSTAMP, v); chk("state stamp", s0 + tarVal, v);
      inputEdgePin <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    // Masked events, then unmask and clear
    rd(`APL_OFS_ISR, v); chk("isr edges", 32'h6, v);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`APL_OFS_IMR, 32'h6);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`APL_OFS_ISR, 32'h6);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq w1c", 32'h0, {31'h0, irq});
    // Correction on the current target, then one refused for lack of request
    switchOnFlag <= 1'b1;
    run_corr(32'h030f);
    rd(`APL_OFS_TAR, v); chk("current target", 32'h7, v);
    rd(`APL_OFS_TAR_OLD, v); chk("old target kept", 32'h3, v);
    rd(`APL_OFS_ADDAMT, v); chk("amount again", 32'h5, v);
    wr(`APL_OFS_CTRL, 32'h0109);
    rd(`APL_OFS_CTRL, v); chk("no request", 32'h0101, v);
    rd(`APL_OFS_ADDAMT, v); chk("amount kept", 32'h5, v);
    rd(`APL_OFS_PCNT, v); chk("pulse count", 32'hc, v);
    test_done();
  end
endmodule : test_apl_angle_pll
